// ==== rtl/tpt_top.sv ====
// module: timer time base with three timers, pwm, compare array and watchdog
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
// Behaviour
// (R1) timers advance every clock by default
// (R2) shared prescaler, 1011 gives every 12 clocks
// (R3) select 0001 makes timer two count every two
// (R4) count and capture pins sampled every clock
// (R5) timer two same rate in all modes
// (R6) mode 0 width selectable 9 to 16
// (R7) mode 1 16-bit auto-reload on overflow
// (R8) each of timers zero/one drives 8-bit pwm
// (R9) timer two feeds four-channel compare pwm
// (R10) watchdog counts per clock, prescaler slows it
// (R11) serial mode 0 shift at clock/4
// (R12) baud timer one counts at full clock
// (R13) reset pin low two clocks resets
// (R14) counter mode counts sampled falling edges
// (R15) select zero means no division
module tpt_top import tpt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic reset_pin_n,
  // timer pins
  input wire logic timer_zero_count_input,
  input wire logic timer_one_count_input,
  input wire logic timer_two_count_input,
  input wire logic timer_two_capture_reload_input,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer outputs
  output logic t0_pwm_out,
  output logic t1_pwm_out,
  output logic [NUM_CC-1:0] cc_pwm_out,
  output logic t2_clock_out,
  output logic uart_shift_tick,
  output logic uart_baud_tick,
  output logic wdt_timeout,
  output logic pin_reset_active
);
  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [TMR_W-1:0] width_mask(input logic [2:0] sel);
    width_mask = TMR_MAX >> (3'h7 - sel);
  endfunction
  // {wrap, next}; mode 0 wraps to zero, mode 1 reloads
  function automatic logic [TMR_W:0] step(input logic [TMR_W-1:0] cnt,
      input logic [TMR_W-1:0] rld, input logic auto, input logic [2:0] sel);
    logic [TMR_W-1:0] m;
    logic wrap;
    m = auto ? TMR_MAX : width_mask(sel);
    wrap = (cnt & m) == m;
    step = {wrap, wrap ? (auto ? rld : TMR_RST) : ((cnt + 16'h0001) & m)};
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------
  // pin reset filter
  // ----------------------------------------
  logic [1:0] rst_hist_q;
  wire soft_rst = rst_hist_q == RST_HIST_HIT; // see (R13)
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_hist_q <= RST_HIST_IDLE;
    end else begin
      rst_hist_q <= {rst_hist_q[0], reset_pin_n}; // see (R13)
    end
  end
  assign pin_reset_active = soft_rst;

  // ----------------------------------------
  // prescaler and pin sampling
  // ----------------------------------------
  tpt_tick_if tk ();
  tpt_prescaler u_presc (.clk(clk), .reset(reset), .soft_rst(soft_rst), .tk(tk.presc));
  tpt_edge_sample u_edges (.clk(clk), .reset(reset), .soft_rst(soft_rst), .ed(tk.edges));
  assign tk.pins = {timer_two_capture_reload_input, timer_two_count_input,
                    timer_one_count_input, timer_zero_count_input};

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  tpt_wr_t wr_q, wr_d;
  tpt_rd_t rd_q;
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rd_word;
  logic rd_hit, wr_hit;
  assign s_axi_awready = (wr_q == WR_COLLECT) && !aw_have_q;
  assign s_axi_wready = (wr_q == WR_COLLECT) && !w_have_q;
  assign s_axi_bvalid = wr_q == WR_RESP;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = rd_q == RD_IDLE;
  assign s_axi_rvalid = rd_q == RD_RESP;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire both_in = (aw_have_q || aw_take) && (w_have_q || w_take);
  wire commit = wr_q == WR_COMMIT;
  always_comb begin
    wr_d = wr_q;
    unique case (wr_q)
      WR_COLLECT: if (both_in) wr_d = WR_COMMIT;
      WR_COMMIT: wr_d = WR_RESP;
      WR_RESP: if (s_axi_bready) wr_d = WR_COLLECT;
      default: wr_d = WR_COLLECT;
    endcase
  end
  // write strobes per register
  wire wr_ctrl = commit && waddr_q == A_CTRL;
  wire wr_t0 = commit && waddr_q == A_T0_CNT;
  wire wr_t0r = commit && waddr_q == A_T0_RLD;
  wire wr_t1 = commit && waddr_q == A_T1_CNT;
  wire wr_t1r = commit && waddr_q == A_T1_RLD;
  wire wr_t2 = commit && waddr_q == A_T2_CNT;
  wire wr_t2r = commit && waddr_q == A_T2_RLD;
  wire wr_pwm = commit && waddr_q == A_PWM;
  wire wr_wdt = commit && waddr_q == A_WDT;
  wire wr_stat = commit && waddr_q == A_STAT;
  // unaligned compare offsets get an error and must not land
  wire wr_cmp = commit && waddr_q[7:4] == A_CMP_A[7:4] && waddr_q[1:0] == 2'h0;

  // ----------------------------------------
  // registers and counters
  // ----------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [TMR_W-1:0] t0_q, t0r_q, t1_q, t1r_q, t2_q, t2r_q, wdt_q;
  logic [2*PWM_W-1:0] duty_q;
  logic [TMR_W-1:0] cmp_q [NUM_CC];
  logic [STAT_W-1:0] stat_q;
  logic [1:0] u0_q;
  logic t0_pwm_q, t1_pwm_q, t2_clk_q, baud_q, wdt_to_q;
  logic [NUM_CC-1:0] cc_q;
  wire [31:0] wword = merge(rd_word, wdata_q, wstrb_q);
  assign tk.timer_prescale_select = ctrl_q[F_TPS +: TPS_W];
  // counter mode uses pin edges, else the prescaled tick (every clock for timer one in baud mode)
  wire t1_tick = ctrl_q[F_T1_BAUD] ? 1'b1 : tk.tick; // see (R12)
  wire inc0 = ctrl_q[F_T0_RUN] && (ctrl_q[F_T0_CNT] ? tk.fall[0] : tk.tick); // see (R1) (R14)
  wire inc1 = ctrl_q[F_T1_RUN] && (ctrl_q[F_T1_CNT] ? tk.fall[1] : t1_tick); // see (R1) (R14)
  // one increment source whatever the timer two mode
  wire inc2 = ctrl_q[F_T2_RUN] && (ctrl_q[F_T2_CNT] ? tk.fall[2] : tk.tick); // see (R5) (R3)
  wire ex_ev = tk.fall[3];
  wire [TMR_W:0] s0 = step(t0_q, t0r_q, ctrl_q[F_T0_AUTO], ctrl_q[F_T0_WID +: 3]); // see (R6)
  wire [TMR_W:0] s1 = step(t1_q, t1r_q, ctrl_q[F_T1_AUTO], ctrl_q[F_T1_WID +: 3]); // see (R7)
  wire ovf0 = inc0 && s0[TMR_W];
  wire ovf1 = inc1 && s1[TMR_W];
  wire ovf2 = inc2 && t2_q == TMR_MAX;
  wire wdt_inc = ctrl_q[F_WDT_RUN] && tk.tick; // see (R10)
  wire wdt_wrap = wdt_inc && wdt_q == TMR_MAX;
  wire [STAT_W-1:0] stat_set = {wdt_wrap, ex_ev, ovf2, ovf1, ovf0};
  // a flag raised in the clearing cycle survives
  wire [STAT_W-1:0] stat_d = (stat_q & ~(wr_stat ? wword[STAT_W-1:0] : '0)) | stat_set;
  wire t2_cap = ctrl_q[F_T2_CAP];
  wire [TMR_W-1:0] t2_d = wr_t2 ? wword[TMR_W-1:0] : ovf2 ? t2r_q :
                          (ex_ev && !t2_cap) ? t2r_q : inc2 ? t2_q + 16'h0001 : t2_q;
  wire [TMR_W-1:0] t2r_d = wr_t2r ? wword[TMR_W-1:0] : (ex_ev && t2_cap) ? t2_q : t2r_q;

  // read mux
  assign rd_hit = s_axi_araddr inside {A_CTRL, A_T0_CNT, A_T0_RLD, A_T1_CNT, A_T1_RLD,
    A_T2_CNT, A_T2_RLD, A_PWM, A_CMP_A, A_CMP_B, A_CMP_C, A_CMP_D, A_WDT, A_STAT};
  assign wr_hit = s_axi_awaddr inside {A_CTRL, A_T0_CNT, A_T0_RLD, A_T1_CNT, A_T1_RLD,
    A_T2_CNT, A_T2_RLD, A_PWM, A_CMP_A, A_CMP_B, A_CMP_C, A_CMP_D, A_WDT, A_STAT};
  wire [ADDR_W-1:0] mux_addr = commit ? waddr_q : s_axi_araddr;
  always_comb begin
    unique case (mux_addr)
      A_CTRL: rd_word = 32'(ctrl_q);
      A_T0_CNT: rd_word = 32'(t0_q);
      A_T0_RLD: rd_word = 32'(t0r_q);
      A_T1_CNT: rd_word = 32'(t1_q);
      A_T1_RLD: rd_word = 32'(t1r_q);
      A_T2_CNT: rd_word = 32'(t2_q);
      A_T2_RLD: rd_word = 32'(t2r_q);
      A_PWM: rd_word = 32'(duty_q);
      A_CMP_A, A_CMP_B, A_CMP_C, A_CMP_D: rd_word = 32'(cmp_q[mux_addr[3:2]]);
      A_WDT: rd_word = 32'(wdt_q);
      A_STAT: rd_word = 32'(stat_q);
      default: rd_word = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // bus state
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q <= WR_COLLECT;
      rd_q <= RD_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      wr_q <= wr_d;
      aw_have_q <= (aw_have_q || aw_take) && !commit;
      w_have_q <= (w_have_q || w_take) && !commit;
      if (aw_take) begin
        waddr_q <= s_axi_awaddr;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      // read answered the cycle after the address is taken
      if (ar_take) begin
        rd_q <= RD_RESP;
        rdata_q <= commit ? 32'h00000000 : rd_word;
        rresp_q <= rd_hit && !commit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rd_q <= RD_IDLE;
      end
    end
  end

  // ----------------------------------------
  // timers, compare array, watchdog
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RST;
      {t0_q, t0r_q, t1_q, t1r_q, t2_q, t2r_q, wdt_q} <= '0;
      duty_q <= '0;
      for (int i = 0; i < NUM_CC; i++) cmp_q[i] <= TMR_RST;
      stat_q <= '0;
    end else if (soft_rst) begin // see (R13)
      ctrl_q <= CTRL_RST;
      {t0_q, t0r_q, t1_q, t1r_q, t2_q, t2r_q, wdt_q} <= '0;
      duty_q <= '0;
      for (int i = 0; i < NUM_CC; i++) cmp_q[i] <= TMR_RST;
      stat_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= wword[CTRL_W-1:0];
      t0_q <= wr_t0 ? wword[TMR_W-1:0] : inc0 ? s0[TMR_W-1:0] : t0_q; // see (R6) (R7)
      t1_q <= wr_t1 ? wword[TMR_W-1:0] : inc1 ? s1[TMR_W-1:0] : t1_q; // see (R12)
      if (wr_t0r) t0r_q <= wword[TMR_W-1:0];
      if (wr_t1r) t1r_q <= wword[TMR_W-1:0];
      t2_q <= t2_d; // see (R5)
      t2r_q <= t2r_d;
      if (wr_pwm) duty_q <= wword[2*PWM_W-1:0];
      if (wr_cmp) cmp_q[waddr_q[3:2]] <= wword[TMR_W-1:0];
      wdt_q <= wr_wdt ? TMR_RST : wdt_inc ? wdt_q + 16'h0001 : wdt_q; // see (R10)
      stat_q <= stat_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {t0_pwm_q, t1_pwm_q, t2_clk_q, baud_q, wdt_to_q} <= '0;
      cc_q <= '0;
      u0_q <= 2'h0;
    end else if (soft_rst) begin
      {t0_pwm_q, t1_pwm_q, t2_clk_q, baud_q, wdt_to_q} <= '0;
      cc_q <= '0;
      u0_q <= 2'h0;
    end else begin
      t0_pwm_q <= t0_q[PWM_W-1:0] < duty_q[PWM_W-1:0]; // see (R8)
      t1_pwm_q <= t1_q[PWM_W-1:0] < duty_q[2*PWM_W-1:PWM_W]; // see (R8)
      for (int i = 0; i < NUM_CC; i++) cc_q[i] <= t2_q < cmp_q[i]; // see (R9)
      t2_clk_q <= t2_clk_q ^ ovf2;
      baud_q <= ovf1; // see (R12)
      wdt_to_q <= wdt_wrap;
      u0_q <= u0_q + 2'h1; // see (R11)
    end
  end
  assign t0_pwm_out = t0_pwm_q;
  assign t1_pwm_out = t1_pwm_q;
  assign cc_pwm_out = cc_q;
  assign t2_clock_out = t2_clk_q;
  assign uart_baud_tick = baud_q;
  assign wdt_timeout = wdt_to_q;
  // free-running, fixed quarter rate regardless of prescale
  assign uart_shift_tick = u0_q == UART0_LAST;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_quarter;
    !uart_shift_tick ##1 !uart_shift_tick ##1 !uart_shift_tick ##1 uart_shift_tick;
  endsequence
  a_uart_quarter_rate: assert property (disable iff (reset || soft_rst) // see (R11)
    uart_shift_tick |=> s_quarter) else $error("shift tick not every 4 clocks");
  a_pin_reset_two: assert property ( // see (R13)
    !reset_pin_n ##1 !reset_pin_n |=> ##1 t0_q == TMR_RST && ctrl_q == CTRL_RST)
    else $error("pin reset not taken");
  a_mode0_width_wrap: assert property ( // see (R6)
    !soft_rst && !wr_t0 && inc0 && !ctrl_q[F_T0_AUTO] && s0[TMR_W] |=> t0_q == TMR_RST)
    else $error("mode 0 wrap wrong");
  a_mode1_auto_reload: assert property ( // see (R7)
    !soft_rst && !wr_t0 && !wr_t0r && inc0 && ctrl_q[F_T0_AUTO] && t0_q == TMR_MAX
    |=> t0_q == $past(t0r_q)) else $error("mode 1 reload wrong");
  a_counter_edge_only: assert property ( // see (R14)
    !soft_rst && !wr_t0 && ctrl_q[F_T0_CNT] && !tk.fall[0] |=> t0_q == $past(t0_q))
    else $error("counter moved without edge");
  a_t1_baud_full: assert property ( // see (R12)
    !soft_rst && !wr_t1 && ctrl_q[F_T1_RUN] && ctrl_q[F_T1_BAUD] && !ctrl_q[F_T1_CNT]
    && !s1[TMR_W] |=> t1_q == $past(t1_q) + 16'h0001) else $error("baud timer slow");
  a_t2_same_rate: assert property ( // see (R5)
    !soft_rst && !wr_t2 && inc2 && !ex_ev && t2_q != TMR_MAX |=> t2_q == $past(t2_q) + 16'h0001)
    else $error("timer two rate wrong");
  a_wdt_prescaled: assert property ( // see (R10)
    !soft_rst && !wr_wdt && ctrl_q[F_WDT_RUN] && !tk.tick |=> wdt_q == $past(wdt_q))
    else $error("watchdog ignored prescaler");
  a_pwm_duty_high: assert property ( // see (R8)
    !soft_rst && t0_q[PWM_W-1:0] == 8'h00 && duty_q[PWM_W-1:0] != 8'h00 |=> t0_pwm_out)
    else $error("pwm low at start");
  a_cc_compare_low: assert property ( // see (R9)
    !soft_rst && t2_q >= cmp_q[0] |=> !cc_pwm_out[0]) else $error("compare output high");
endmodule // tpt_top

// ==== rtl/tpt_pkg.sv ====
// package: register map, field layout and timing constants of the timer base
package tpt_pkg;
  localparam int TMR_W = 16;
  localparam int TPS_W = 4;
  localparam int PWM_W = 8;
  localparam int NUM_CC = 4;
  localparam int NUM_PIN = 4;
  localparam int ADDR_W = 8;
  localparam int CTRL_W = 21;
  localparam int STAT_W = 5;
  // byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_T0_CNT = 8'h04;
  localparam logic [7:0] A_T0_RLD = 8'h08;
  localparam logic [7:0] A_T1_CNT = 8'h0C;
  localparam logic [7:0] A_T1_RLD = 8'h10;
  localparam logic [7:0] A_T2_CNT = 8'h14;
  localparam logic [7:0] A_T2_RLD = 8'h18;
  localparam logic [7:0] A_PWM = 8'h1C;
  localparam logic [7:0] A_CMP_A = 8'h20;
  localparam logic [7:0] A_CMP_B = 8'h24;
  localparam logic [7:0] A_CMP_C = 8'h28;
  localparam logic [7:0] A_CMP_D = 8'h2C;
  localparam logic [7:0] A_WDT = 8'h30;
  localparam logic [7:0] A_STAT = 8'h34;
  // control field positions
  localparam int F_TPS = 0;
  localparam int F_T0_RUN = 4;
  localparam int F_T1_RUN = 5;
  localparam int F_T2_RUN = 6;
  localparam int F_T0_CNT = 7;
  localparam int F_T1_CNT = 8;
  localparam int F_T2_CNT = 9;
  localparam int F_T0_AUTO = 10;
  localparam int F_T1_AUTO = 11;
  localparam int F_T0_WID = 12;
  localparam int F_T1_WID = 15;
  localparam int F_WDT_RUN = 18;
  localparam int F_T2_CAP = 19;
  localparam int F_T1_BAUD = 20;
  // status bit positions
  localparam int S_T0 = 0;
  localparam int S_T1 = 1;
  localparam int S_T2 = 2;
  localparam int S_EX = 3;
  localparam int S_WDT = 4;
  // reset values and codes
  localparam logic [CTRL_W-1:0] CTRL_RST = 21'h000000;
  localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_MAX = 16'hFFFF;
  localparam logic [TPS_W-1:0] TPS_NONE = 4'h0;
  localparam logic [TPS_W-1:0] TPS_DIV2 = 4'h1;
  localparam logic [TPS_W-1:0] TPS_DIV12 = 4'hB;
  localparam logic [1:0] UART0_LAST = 2'h3;
  localparam logic [1:0] RST_HIST_IDLE = 2'h3;
  localparam logic [1:0] RST_HIST_HIT = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {WR_COLLECT = 2'b00, WR_COMMIT = 2'b01, WR_RESP = 2'b11} tpt_wr_t;
  typedef enum logic {RD_IDLE = 1'b0, RD_RESP = 1'b1} tpt_rd_t;
endpackage

// ==== rtl/tpt_tick_if.sv ====
// interface: prescale tick and sampled pin edges between the timer modules
`timescale 1ns/10ps
interface tpt_tick_if;
  import tpt_pkg::*;
  logic [TPS_W-1:0] timer_prescale_select;
  logic tick;
  logic [NUM_PIN-1:0] pins;
  logic [NUM_PIN-1:0] fall;
  modport presc (input timer_prescale_select, output tick);
  modport edges (input pins, output fall);
  modport core (output timer_prescale_select, output pins, input tick, input fall);
endinterface

// ==== rtl/tpt_prescaler.sv ====
// module: shared time-base prescaler for all timers and the watchdog
`timescale 1ns/10ps
module tpt_prescaler import tpt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic soft_rst,
  // tick carrier
  tpt_tick_if.presc tk
);
  logic [TPS_W-1:0] cnt_q, cnt_d, tps_q;
  wire tps_moved = tk.timer_prescale_select != tps_q;
  // divide by select plus one; zero means every clock
  assign tk.tick = cnt_q == tk.timer_prescale_select; // see (R2) see (R15)
  // restart on a select change so no stale count overshoots
  assign cnt_d = (tk.tick || tps_moved) ? '0 : cnt_q + 4'h1;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      tps_q <= TPS_NONE;
    end else if (soft_rst) begin
      cnt_q <= '0;
      tps_q <= TPS_NONE;
    end else begin
      cnt_q <= cnt_d;
      tps_q <= tk.timer_prescale_select;
    end
  end
  wire d12 = tk.timer_prescale_select == TPS_DIV12;
  wire d2 = tk.timer_prescale_select == TPS_DIV2;
  sequence s_d12_gap;
    (tk.tick && d12) ##1 (d12 && !tk.tick)[*8] ##1 (d12 && !tk.tick)[*3] ##1 d12;
  endsequence
  a_presc_div_twelve: assert property (@(posedge clk) disable iff (reset || soft_rst) // see (R2)
    s_d12_gap |-> tk.tick) else $error("prescaler 1011 not every 12 clocks");
  a_presc_div_two: assert property (@(posedge clk) disable iff (reset || soft_rst) // see (R3)
    (tk.tick && d2) ##1 d2 |-> !tk.tick ##1 (!d2 || tk.tick)) else $error("div2 tick wrong");
  a_presc_no_div: assert property (@(posedge clk) disable iff (reset || soft_rst) // see (R15)
    tk.timer_prescale_select == TPS_NONE && $past(tk.timer_prescale_select) == TPS_NONE |-> tk.tick) else $error("tps 0 divides");
endmodule // tpt_prescaler

// ==== rtl/tpt_edge_sample.sv ====
// module: per-clock sampling and falling-edge detection of timer pins
`timescale 1ns/10ps
module tpt_edge_sample import tpt_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic soft_rst,
  // pin carrier
  tpt_tick_if.edges ed
);
  logic [NUM_PIN-1:0] samp_q, prev_q;
  // idle high, so a pin low at start is taken as a falling edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      samp_q <= '1;
      prev_q <= '1;
    end else if (soft_rst) begin
      samp_q <= '1;
      prev_q <= '1;
    end else begin
      samp_q <= ed.pins; // see (R4)
      prev_q <= samp_q;
    end
  end
  assign ed.fall = prev_q & ~samp_q; // see (R14)
  a_pin_fall_seen: assert property (@(posedge clk) disable iff (reset || soft_rst) // see (R14)
    $fell(ed.pins[0]) |=> ed.fall[0] ##1 !ed.fall[0]) else $error("pin edge missed");
  a_pin_each_clock: assert property (@(posedge clk) disable iff (reset || soft_rst) // see (R4)
    ed.pins[3] && $past(ed.pins[3]) |=> !ed.fall[3]) else $error("false capture edge");
endmodule // tpt_edge_sample

// ==== dv/tpt_pin_model.sv ====
// pin model: external count, capture and reset pins of the timer block
`timescale 1ns/10ps
module tpt_pin_model (
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic [3:0] edge_req,
  input wire logic rst_req,
  // pins, pulled high when released
  output logic [3:0] pins,
  output logic reset_pin_n
);
  initial begin
    pins = 4'hF;
    reset_pin_n = 1'h1;
  end
  // one-clock low pulses, so a slow sampler would miss them
  always @(posedge clk) begin
    pins <= ~edge_req;
    reset_pin_n <= ~rst_req;
  end
endmodule // tpt_pin_model

// ==== dv/timer_prescaler_timebase_tb.sv ====
// testbench: timer time base driven over its register bus and pins
`timescale 1ns/10ps
module timer_prescaler_timebase_tb;
  import tpt_pkg::*;
  typedef struct {logic [31:0] c; logic [7:0] a; int dv;} tpt_row_t;
  logic clk, reset = 1'h1, rreq = 1'h0, rpn, t0p, t1p, ctk, sht, bdt, wdo, pra;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF, ccp, pins, ereq = 4'h0;
  logic [1:0] bresp, rresp;
  int n_fail = 0, total_checks = 0, cyc = 0, tk = 0;
  wire [7:0] pw = {pra, sht, ccp, t1p, t0p};
  // --------------------------------------------------
  // rate rows: control word, counter read, divide
  // --------------------------------------------------
  tpt_row_t rows [9] = '{
    '{32'h00000410, A_T0_CNT, 1}, '{32'h0000041B, A_T0_CNT, 12},
    '{32'h00000041, A_T2_CNT, 2}, '{32'h00080040, A_T2_CNT, 1},
    '{32'h0000082B, A_T1_CNT, 12}, '{32'h0010082B, A_T1_CNT, 1},
    '{32'h0004000B, A_WDT, 12}, '{32'h00040000, A_WDT, 1}, '{32'h00000040, A_T2_CNT, 1}};
  logic [31:0] cm [3] = '{32'h490, 32'h920, 32'h240};
  logic [7:0] ca [3] = '{A_T0_CNT, A_T1_CNT, A_T2_CNT};
  logic [31:0] cc [4] = '{32'hFF40, 32'hFF80, 32'hFFC0, 32'h0};
  logic [31:0] ce [4] = '{32'h40, 32'h80, 32'hC0, 32'h0};
  tpt_pin_model u_pin (.clk(clk), .edge_req(ereq), .rst_req(rreq), .pins(pins),
    .reset_pin_n(rpn));
  tpt_top u_dut (.clk(clk), .reset(reset), .reset_pin_n(rpn),
    .timer_zero_count_input(pins[0]), .timer_one_count_input(pins[1]),
    .timer_two_count_input(pins[2]), .timer_two_capture_reload_input(pins[3]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .t0_pwm_out(t0p), .t1_pwm_out(t1p), .cc_pwm_out(ccp), .t2_clock_out(ctk),
    .uart_shift_tick(sht), .uart_baud_tick(bdt), .wdt_timeout(wdo), .pin_reset_active(pra));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic na, nw;
    int k = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk);
      na = awvalid && awready;
      nw = wvalid && wready;
      @(posedge clk);
      if (na) awvalid <= 1'h0;
      if (nw) wvalid <= 1'h0;
      k++;
    end while ((awvalid && !na || wvalid && !nw) && k < 50);
    do begin
      @(negedge clk);
      k++;
    end while (!bvalid && k < 100);
    r = bresp;
    @(posedge clk);
    bready <= 1'h0;
    if (k >= 100) n_fail++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(negedge clk);
      k++;
    end while (!arready && k < 50);
    tk = cyc + 1;
    @(posedge clk);
    arvalid <= 1'h0;
    do begin
      @(negedge clk);
      k++;
    end while (!rvalid && k < 100);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'h0;
    if (k >= 100) n_fail++;
  endtask
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      @(posedge clk);
      ereq[i] <= 1'h1;
      @(posedge clk);
      ereq[i] <= 1'h0;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic hi(input int n, output int h [8]);
    h = '{default: 0};
    repeat (n) begin
      @(negedge clk);
      for (int j = 0; j < 8; j++) h[j] += int'(pw[j]);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // --------------------------------------------------
  // sequence
  // --------------------------------------------------
  initial begin
    logic [31:0] d, v;
    logic [1:0] r;
    int t1;
    int h [8];
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    rd(A_CTRL, d, r);
    ck(d, 32'(CTRL_RST), "ctrl after reset");
    foreach (rows[i]) begin
      wr(A_CTRL, rows[i].c, r);
      rd(rows[i].a, d, r);
      t1 = tk;
      @(negedge clk);
      while (cyc < t1 + 118) @(negedge clk);
      rd(rows[i].a, v, r);
      ck(32'(16'(v[15:0] - d[15:0])), 32'((tk - t1) / rows[i].dv), "rate");
    end
    foreach (cm[i]) begin
      wr(A_CTRL, cm[i], r);
      rd(ca[i], d, r);
      pulse(i, 5);
      rd(ca[i], v, r);
      ck(32'(16'(v[15:0] - d[15:0])), 32'h5, "pin count");
    end
    wr(A_STAT, 32'h1F, r);
    pulse(3, 1);
    rd(A_STAT, d, r);
    ck(32'(d[S_EX]), 32'h1, "capture edge");
    wr(A_CTRL, 32'h10, r);
    wr(A_T0_CNT, 32'h1F0, r);
    wr(A_STAT, 32'h1F, r);
    repeat (30) @(posedge clk);
    rd(A_T0_CNT, d, r);
    ck(32'(d < 32'h40), 32'h1, "nine-bit wrap");
    rd(A_STAT, v, r);
    ck(32'(v[S_T0]), 32'h1, "overflow flag");
    wr(A_T0_RLD, 32'h1234, r);
    wr(A_CTRL, 32'h410, r);
    wr(A_T0_CNT, 32'hFFF0, r);
    repeat (30) @(posedge clk);
    rd(A_T0_CNT, d, r);
    ck(32'(d >= 32'h1234 && d < 32'h1260), 32'h1, "auto reload");
    wr(A_PWM, 32'h4080, r);
    wr(A_CTRL, 32'hC30, r);
    hi(256, h);
    ck(h[0], 32'h80, "t0 duty");
    ck(h[1], 32'h40, "t1 duty");
    wr(A_CTRL, 32'h40, r);
    wr(A_T2_RLD, 32'hFF00, r);
    wr(A_T2_CNT, 32'hFF00, r);
    foreach (cc[i]) wr(8'(A_CMP_A + 4 * i), cc[i], r);
    @(negedge clk);
    v = 32'(ctk);
    hi(256, h);
    foreach (ce[i]) ck(h[2 + i], ce[i], "compare duty");
    ck(32'(ctk ^ v[0]), 32'h1, "clock out toggle");
    // baud timer preset near the top: one overflow pulse in the window
    wr(A_CTRL, 32'h100820, r);
    wr(A_T1_CNT, 32'hFFF8, r);
    t1 = 0;
    repeat (40) begin
      @(negedge clk);
      t1 += int'(bdt);
    end
    ck(t1, 32'h1, "baud tick");
    hi(400, h);
    ck(h[6], 32'h64, "shift ticks");
    @(posedge clk);
    rreq <= 1'h1;
    @(posedge clk);
    rreq <= 1'h0;
    hi(8, h);
    ck(h[7], 32'h0, "short low ignored");
    @(posedge clk);
    rreq <= 1'h1;
    repeat (3) @(posedge clk);
    rreq <= 1'h0;
    hi(8, h);
    ck(32'(h[7] > 0), 32'h1, "pin reset seen");
    rd(A_CTRL, d, r);
    ck(d, 32'(CTRL_RST), "ctrl cleared");
    rd(8'h3C, d, r);
    ck(32'(r), 32'(RESP_SLVERR), "unmapped read");
    wr(8'h40, 32'hFFFF, r);
    ck(32'(r), 32'(RESP_SLVERR), "unmapped write");
    conclude();
  end
  // long runs stop here
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule // timer_prescaler_timebase_tb
